/* File: rtl/lcs_pkg.sv */
package lcs_pkg;
   // ----------------------------------------
   // Bus geometry
   // ----------------------------------------
   localparam int unsigned NUM_LINKS = 8;
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 32;
   localparam logic [1:0] WORD_ALIGN = 2'h0;
   // Register indices; byte address is four times the index
   localparam logic [9:0] CFG_BASE_IDX = 10'h080;
   localparam logic [9:0] STATIC_BASE_IDX = 10'h0A0;
   localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

   // ----------------------------------------
   // Link configuration fields
   // ----------------------------------------
   localparam int unsigned CFG_EN_BIT = 31;
   localparam int unsigned CFG_WIDE_BIT = 30;
   localparam int unsigned CFG_ERR_BIT = 27;
   localparam int unsigned CFG_CRED_ISSUED_BIT = 26;
   localparam int unsigned CFG_CRED_HELD_BIT = 25;
   localparam int unsigned CFG_GREET_BIT = 24;
   localparam int unsigned CFG_RESYNC_BIT = 23;
   localparam int unsigned GAP_W = 11;
   localparam int unsigned TRANS_GAP_LSB = 11;
   localparam int unsigned TRANS_GAP_MSB = 21;
   localparam int unsigned TOKEN_GAP_LSB = 0;
   localparam int unsigned TOKEN_GAP_MSB = 10;

   // ----------------------------------------
   // Static forwarding fields
   // ----------------------------------------
   localparam int unsigned STATIC_EN_BIT = 31;
   localparam int unsigned CHAN_W = 5;
   localparam int unsigned CHAN_LSB = 0;
   localparam int unsigned CHAN_MSB = 4;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic EN_RST = 1'h0;
   localparam logic WIDE_RST = 1'h0;
   localparam logic ERR_RST = 1'h0;
   localparam logic PULSE_RST = 1'h0;
   localparam logic [GAP_W-1:0] GAP_RST = 11'h000;
   localparam logic [CHAN_W-1:0] CHAN_RST = 5'h00;
endpackage

/* File: rtl/lcs_link_cfg.sv */
module lcs_link_cfg
   import lcs_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Register access, already decoded for this link
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [DATA_W-1:0] wdata_in,
   // Link events and credit state
   input wire logic rx_ovf_in,
   input wire logic bad_tok_in,
   input wire logic cred_issued_in,
   input wire logic cred_held_in,
   // Controls
   output logic en_out,
   output logic wide_out,
   output logic greet_out,
   output logic resync_out,
   output logic err_out,
   output logic [GAP_W-1:0] trans_gap_out,
   output logic [GAP_W-1:0] tok_gap_out,
   output logic [DATA_W-1:0] rdata_out
);
   logic en_ff, wide_ff, err_ff, greet_ff, resync_ff;
   logic [GAP_W-1:0] trans_gap_ff, tok_gap_ff;
   wire logic err_evt = rx_ovf_in | bad_tok_in;
   // Set beats the read clear, so an error in the read cycle survives
   wire logic nxt_err = err_evt | (err_ff & ~rd_in);
   wire logic nxt_greet = wr_in & wdata_in[CFG_GREET_BIT];
   wire logic nxt_resync = wr_in & wdata_in[CFG_RESYNC_BIT];

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         en_ff <= EN_RST;
         wide_ff <= WIDE_RST;
         err_ff <= ERR_RST;
         greet_ff <= PULSE_RST;
         resync_ff <= PULSE_RST;
         trans_gap_ff <= GAP_RST;
         tok_gap_ff <= GAP_RST;
      end else begin
         err_ff <= nxt_err;
         greet_ff <= nxt_greet;
         resync_ff <= nxt_resync;
         if (wr_in) begin
            en_ff <= wdata_in[CFG_EN_BIT];
            wide_ff <= wdata_in[CFG_WIDE_BIT];
            trans_gap_ff <= wdata_in[TRANS_GAP_MSB:TRANS_GAP_LSB];
            tok_gap_ff <= wdata_in[TOKEN_GAP_MSB:TOKEN_GAP_LSB];
         end
      end
   end

   assign en_out = en_ff;
   assign wide_out = wide_ff;
   assign err_out = err_ff;
   assign greet_out = greet_ff;
   assign resync_out = resync_ff;
   assign trans_gap_out = trans_gap_ff;
   assign tok_gap_out = tok_gap_ff;
   // Self-clearing bits read back as zero
   always_comb begin
      rdata_out = '0;
      rdata_out[CFG_EN_BIT] = en_ff;
      rdata_out[CFG_WIDE_BIT] = wide_ff;
      rdata_out[CFG_ERR_BIT] = err_ff;
      rdata_out[CFG_CRED_ISSUED_BIT] = cred_issued_in;
      rdata_out[CFG_CRED_HELD_BIT] = cred_held_in;
      rdata_out[TRANS_GAP_MSB:TRANS_GAP_LSB] = trans_gap_ff;
      rdata_out[TOKEN_GAP_MSB:TOKEN_GAP_LSB] = tok_gap_ff;
   end

   AST_ERR_SET: assert property (@(posedge clk_in) disable iff (rst_in)
      err_evt |=> err_ff) else $error("error flag missed an event");
   AST_ERR_CLR: assert property (@(posedge clk_in) disable iff (rst_in)
      rd_in && !err_evt |=> !err_ff) else $error("error flag not cleared by read");
   AST_GREET_ONE: assert property (@(posedge clk_in) disable iff (rst_in)
      greet_ff && !$past(wr_in) |-> 1'b0) else $error("greeting pulse without write");
endmodule // lcs_link_cfg

/* File: rtl/lcs_static_fwd.sv */
module lcs_static_fwd
   import lcs_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Register access, already decoded for this link
   input wire logic wr_in,
   input wire logic [DATA_W-1:0] wdata_in,
   // Forwarding controls
   output logic fwd_en_out,
   output logic [CHAN_W-1:0] chan_out,
   output logic [DATA_W-1:0] rdata_out
);
   logic fwd_en_ff;
   logic [CHAN_W-1:0] chan_ff;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         fwd_en_ff <= EN_RST;
         chan_ff <= CHAN_RST;
      end else if (wr_in) begin
         fwd_en_ff <= wdata_in[STATIC_EN_BIT];
         chan_ff <= wdata_in[CHAN_MSB:CHAN_LSB];
      end
   end

   assign fwd_en_out = fwd_en_ff;
   assign chan_out = chan_ff;
   always_comb begin
      rdata_out = '0;
      rdata_out[STATIC_EN_BIT] = fwd_en_ff;
      rdata_out[CHAN_MSB:CHAN_LSB] = chan_ff;
   end

   AST_STATIC_CHAN: assert property (@(posedge clk_in) disable iff (rst_in)
      wr_in |=> chan_ff == $past(wdata_in[CHAN_MSB:CHAN_LSB])) else $error("channel end not stored");
endmodule // lcs_static_fwd

/* File: rtl/lcs_link_regs.sv */
// Functional notes
// - Config bit 31 enables the link when one, disables when zero; resets zero.
// - The enable bit also hands shared port pins over to the link.
// - Config bit 30 picks two-wire (zero) or five-wire (one) mode; resets zero.
// - Bit 27 sets on receive overflow or bad token, clears when read.
// - Read-only bit 26 shows this end has granted credit to the far end.
// - Read-only bit 25 shows this end holds credit to transmit.
// - Writing one to bit 24 drops own credit and sends the greeting token.
// - Writing one to bit 23 resets the receiver; next symbol opens a token.
// - Bits 21:11 give system clocks between transitions inside a token; reset zero.
// - Bits 10:0 give system clocks between successive tokens; reset zero.
// - Static bit 31 sends all received packets to one channel end, unrouted.
// - Static bits 4:0 name the destination channel end; reset zero.
// - Each bank has eight registers in link order C, D, A, B, G, H, E, F.
//
// The plain strobed port is this design's own decision.
module lcs_link_regs
   import lcs_pkg::*;
(
   // Clock and reset
   input wire logic CORE_CLK_IN,
   input wire logic RST_IN,
   // Register port
   input wire logic [ADDR_W-1:0] ADDR_IN,
   input wire logic [DATA_W-1:0] WR_DATA_IN,
   input wire logic WR_STB_IN,
   input wire logic RD_STB_IN,
   output logic [DATA_W-1:0] RD_DATA_OUT,
   // Link events and credit state, one bit per link
   input wire logic [NUM_LINKS-1:0] RX_OVERFLOW_IN,
   input wire logic [NUM_LINKS-1:0] BAD_TOKEN_IN,
   input wire logic [NUM_LINKS-1:0] CREDIT_ISSUED_IN,
   input wire logic [NUM_LINKS-1:0] CREDIT_HELD_IN,
   // Link controls
   output logic [NUM_LINKS-1:0] LINK_EN_OUT,
   output logic [NUM_LINKS-1:0] PIN_MUX_SEL_OUT,
   output logic [NUM_LINKS-1:0] WIDE_MODE_OUT,
   output logic [NUM_LINKS-1:0] LINK_ERR_OUT,
   output logic [NUM_LINKS-1:0] GREET_INIT_OUT,
   output logic [NUM_LINKS-1:0] RX_RESYNC_OUT,
   output logic [NUM_LINKS*GAP_W-1:0] TRANS_GAP_OUT,
   output logic [NUM_LINKS*GAP_W-1:0] TOKEN_GAP_OUT,
   // Static forwarding
   output logic [NUM_LINKS-1:0] STATIC_FWD_EN_OUT,
   output logic [NUM_LINKS*CHAN_W-1:0] STATIC_CHAN_OUT
);
   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   // Word index i of a bank is link position i in C, D, A, B, G, H, E, F order
   function automatic logic link_hit(input logic [ADDR_W-1:0] addr, input logic [9:0] base,
                                     input logic [2:0] idx);
      link_hit = (addr[1:0] == WORD_ALIGN) && (addr[ADDR_W-1:2] == base + {7'h00, idx});
   endfunction

   logic [NUM_LINKS-1:0] cfg_hit;
   logic [NUM_LINKS-1:0] st_hit;
   logic [DATA_W-1:0] cfg_rdata [NUM_LINKS];
   logic [DATA_W-1:0] st_rdata [NUM_LINKS];
   logic [DATA_W-1:0] rd_data_ff;
   logic [DATA_W-1:0] nxt_rd_data;
   wire logic any_hit = |{cfg_hit, st_hit};

   // ----------------------------------------
   // Per-link register banks
   // ----------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < NUM_LINKS; gi++) begin : g_link
         assign cfg_hit[gi] = link_hit(ADDR_IN, CFG_BASE_IDX, 3'(gi));
         assign st_hit[gi] = link_hit(ADDR_IN, STATIC_BASE_IDX, 3'(gi));

         lcs_link_cfg u_cfg (
            .clk_in(CORE_CLK_IN),
            .rst_in(RST_IN),
            .wr_in(WR_STB_IN & cfg_hit[gi]),
            .rd_in(RD_STB_IN & cfg_hit[gi]),
            .wdata_in(WR_DATA_IN),
            .rx_ovf_in(RX_OVERFLOW_IN[gi]),
            .bad_tok_in(BAD_TOKEN_IN[gi]),
            .cred_issued_in(CREDIT_ISSUED_IN[gi]),
            .cred_held_in(CREDIT_HELD_IN[gi]),
            .en_out(LINK_EN_OUT[gi]),
            .wide_out(WIDE_MODE_OUT[gi]),
            .greet_out(GREET_INIT_OUT[gi]),
            .resync_out(RX_RESYNC_OUT[gi]),
            .err_out(LINK_ERR_OUT[gi]),
            .trans_gap_out(TRANS_GAP_OUT[gi*GAP_W +: GAP_W]),
            .tok_gap_out(TOKEN_GAP_OUT[gi*GAP_W +: GAP_W]),
            .rdata_out(cfg_rdata[gi])
         );

         lcs_static_fwd u_st (
            .clk_in(CORE_CLK_IN),
            .rst_in(RST_IN),
            .wr_in(WR_STB_IN & st_hit[gi]),
            .wdata_in(WR_DATA_IN),
            .fwd_en_out(STATIC_FWD_EN_OUT[gi]),
            .chan_out(STATIC_CHAN_OUT[gi*CHAN_W +: CHAN_W]),
            .rdata_out(st_rdata[gi])
         );

         // Pins follow the enable flop itself, so mux and link never disagree
         assign PIN_MUX_SEL_OUT[gi] = LINK_EN_OUT[gi];

         // ----------------------------------------
         // Checks per link
         // ----------------------------------------
         AST_EN_WR: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
            WR_STB_IN && cfg_hit[gi] |=> LINK_EN_OUT[gi] == $past(WR_DATA_IN[CFG_EN_BIT])
                                         && PIN_MUX_SEL_OUT[gi] == LINK_EN_OUT[gi])
            else $error("link enable not taken from write");
         AST_WIDE_HOLD: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
            !(WR_STB_IN && cfg_hit[gi]) |=> $stable(WIDE_MODE_OUT[gi]))
            else $error("wire mode changed without a write");
         AST_TRANS_GAP: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
            WR_STB_IN && cfg_hit[gi] |=>
               TRANS_GAP_OUT[gi*GAP_W +: GAP_W] == $past(WR_DATA_IN[TRANS_GAP_MSB:TRANS_GAP_LSB]))
            else $error("transition spacing not stored");
         AST_TOKEN_GAP: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
            WR_STB_IN && cfg_hit[gi] |=>
               TOKEN_GAP_OUT[gi*GAP_W +: GAP_W] == $past(WR_DATA_IN[TOKEN_GAP_MSB:TOKEN_GAP_LSB]))
            else $error("token spacing not stored");
         AST_GREET: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
            WR_STB_IN && cfg_hit[gi] && WR_DATA_IN[CFG_GREET_BIT] |=> GREET_INIT_OUT[gi])
            else $error("greeting token not requested");
         AST_RESYNC: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
            !(WR_STB_IN && cfg_hit[gi] && WR_DATA_IN[CFG_RESYNC_BIT]) |=> !RX_RESYNC_OUT[gi])
            else $error("receiver reset did not self-clear");
         AST_CRED_READ: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
            RD_STB_IN && cfg_hit[gi] |=>
               RD_DATA_OUT[CFG_CRED_ISSUED_BIT] == $past(CREDIT_ISSUED_IN[gi])
               && RD_DATA_OUT[CFG_CRED_HELD_BIT] == $past(CREDIT_HELD_IN[gi]))
            else $error("credit status misread");
         AST_ERR_READ: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
            RD_STB_IN && cfg_hit[gi] |=> RD_DATA_OUT[CFG_ERR_BIT] == $past(LINK_ERR_OUT[gi]))
            else $error("error flag misread");
         AST_STATIC_EN: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
            WR_STB_IN && st_hit[gi] |=> STATIC_FWD_EN_OUT[gi] == $past(WR_DATA_IN[STATIC_EN_BIT]))
            else $error("static forwarding enable not stored");
         AST_GREET_CLEAR: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
            !(WR_STB_IN && cfg_hit[gi] && WR_DATA_IN[CFG_GREET_BIT]) |=> !GREET_INIT_OUT[gi])
            else $error("greeting request did not self-clear");
         AST_MODE_READ: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
            RD_STB_IN && cfg_hit[gi] |=>
               RD_DATA_OUT[CFG_WIDE_BIT] == $past(WIDE_MODE_OUT[gi])
               && RD_DATA_OUT[CFG_EN_BIT] == $past(LINK_EN_OUT[gi]))
            else $error("enable or wire mode misread");
         AST_STATIC_READ: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
            RD_STB_IN && st_hit[gi] |=>
               RD_DATA_OUT[STATIC_EN_BIT] == $past(STATIC_FWD_EN_OUT[gi])
               && RD_DATA_OUT[CHAN_MSB:CHAN_LSB] == $past(STATIC_CHAN_OUT[gi*CHAN_W +: CHAN_W]))
            else $error("static forwarding register misread");
      end
   endgenerate

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   // At most one hit per address; unmapped words read as zero
   always_comb begin
      nxt_rd_data = UNMAPPED_DATA;
      for (int i = 0; i < NUM_LINKS; i++) begin
         if (cfg_hit[i]) begin
            nxt_rd_data = cfg_rdata[i];
         end
         if (st_hit[i]) begin
            nxt_rd_data = st_rdata[i];
         end
      end
   end

   // Data are captured on each read strobe and held until the next one
   always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         rd_data_ff <= UNMAPPED_DATA;
      end else if (RD_STB_IN) begin
         rd_data_ff <= nxt_rd_data;
      end
   end

   assign RD_DATA_OUT = rd_data_ff;

   AST_UNMAPPED: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
      RD_STB_IN && !any_hit |=> RD_DATA_OUT == UNMAPPED_DATA)
      else $error("unmapped read not zero");
   // Read data must stand until the next read strobe
   AST_RD_HOLD: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
      !RD_STB_IN |=> $stable(RD_DATA_OUT))
      else $error("read data changed without a read");
endmodule // lcs_link_regs

/* File: bench/lcs_far_end.sv */
module lcs_far_end
   import lcs_pkg::*;
#(
   parameter int REPLY_DLY = 4
)
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Greeting requests from the local end
   input wire logic [NUM_LINKS-1:0] greet_in,
   // Credit seen by the local end
   output logic [NUM_LINKS-1:0] cred_held_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------
   // Remote endpoint credit reply
   // ----------------------------------------
   // No credit until greeted, so a missing greeting shows up as a zero bit 25
   logic [3:0] cnt_ff [NUM_LINKS];
   always_ff @(posedge clk_in or posedge rst_in) begin
      for (int i = 0; i < NUM_LINKS; i++) begin
         if (rst_in) begin
            cred_held_out[i] <= 1'h0;
            cnt_ff[i] <= 4'h0;
         end else if (greet_in[i]) begin
            cred_held_out[i] <= 1'h0;
            cnt_ff[i] <= 4'(REPLY_DLY);
         end else if (cnt_ff[i] != 4'h0) begin
            cnt_ff[i] <= cnt_ff[i] - 4'h1;
            if (cnt_ff[i] == 4'h1) begin
               cred_held_out[i] <= 1'h1;
            end
         end
      end
   end
endmodule // lcs_far_end

/* File: bench/lcs_link_regs_test.sv */
module lcs_link_regs_test
   import lcs_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst, wr, rd;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata, rdata, d;
   logic [NUM_LINKS-1:0] ovf, bad, issued, held, en, mux, wide, err, greet, resync, sfen;
   logic [NUM_LINKS*GAP_W-1:0] trg, tkg;
   logic [NUM_LINKS*CHAN_W-1:0] chan;
   logic [GAP_W-1:0] tr, tk;
   logic [CHAN_W-1:0] c;
   int miscompares, checked;

   lcs_link_regs uut (.CORE_CLK_IN(clk), .RST_IN(rst), .ADDR_IN(addr), .WR_DATA_IN(wdata),
      .WR_STB_IN(wr), .RD_STB_IN(rd), .RD_DATA_OUT(rdata), .RX_OVERFLOW_IN(ovf),
      .BAD_TOKEN_IN(bad), .CREDIT_ISSUED_IN(issued), .CREDIT_HELD_IN(held), .LINK_EN_OUT(en),
      .PIN_MUX_SEL_OUT(mux), .WIDE_MODE_OUT(wide), .LINK_ERR_OUT(err), .GREET_INIT_OUT(greet),
      .RX_RESYNC_OUT(resync), .TRANS_GAP_OUT(trg), .TOKEN_GAP_OUT(tkg),
      .STATIC_FWD_EN_OUT(sfen), .STATIC_CHAN_OUT(chan));
   lcs_far_end #(.REPLY_DLY(4)) u_far (.clk_in(clk), .rst_in(rst), .greet_in(greet),
      .cred_held_out(held));

   // ----------------------------------------
   // Bus tasks and checking
   // ----------------------------------------
   function automatic logic [ADDR_W-1:0] adr(input logic [9:0] base, input int i);
      return {base + 10'(i), WORD_ALIGN};
   endfunction
   task automatic chk(input logic [DATA_W-1:0] s, input logic [DATA_W-1:0] x);
      checked++;
      if (s !== x) begin
         miscompares++;
         $display("Error at %0t: seen %h expected %h", $time, s, x);
      end
   endtask
   task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
      @(posedge clk);
      wr <= 1'h1;
      addr <= a;
      wdata <= v;
      @(posedge clk);
      wr <= 1'h0;
      #1;
   endtask
   // Optional overflow events ride along with the read strobe
   task automatic rd_reg(input logic [ADDR_W-1:0] a, input logic [NUM_LINKS-1:0] ev,
                         output logic [DATA_W-1:0] v);
      @(posedge clk);
      rd <= 1'h1;
      addr <= a;
      ovf <= ev;
      @(posedge clk);
      rd <= 1'h0;
      ovf <= '0;
      #1 v = rdata;
   endtask
   task automatic report_and_stop();
      $display("Checks %0d, mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   initial begin
      clk = 1'h0;
      forever #50 clk = ~clk;
   end
   initial begin
      repeat (3000) @(posedge clk);
      miscompares++;
      report_and_stop();
   end

   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      rst = 1'h1;
      wr = 1'h0;
      rd = 1'h0;
      addr = '0;
      wdata = '0;
      ovf = '0;
      bad = '0;
      issued = '0;
      miscompares = 0;
      checked = 0;
      repeat (6) @(posedge clk);
      rst <= 1'h0;
      #1 chk({en, mux, wide, err}, 32'h0);
      chk(32'({greet, resync, sfen}), 32'h0);
      for (int i = 0; i < NUM_LINKS; i++) begin
         rd_reg(adr(CFG_BASE_IDX, i), '0, d);
         chk(d, 32'h0);
         rd_reg(adr(STATIC_BASE_IDX, i), '0, d);
         chk(d, 32'h0);
      end
      @(posedge clk);
      issued <= 8'hA5;
      // Read-only and reserved bits written as ones must not stick
      for (int i = 0; i < NUM_LINKS; i++) begin
         tr = 11'h7F8 | 11'(i);
         tk = 11'(i * 11'h0F1);
         wr_reg(adr(CFG_BASE_IDX, i), {1'h1, i[0], 8'hFF, tr, tk});
         chk(32'({en[i], mux[i], wide[i], greet[i], resync[i]}), 32'({2'h3, i[0], 2'h3}));
         chk(32'({trg[i*GAP_W+:GAP_W], tkg[i*GAP_W+:GAP_W]}), 32'({tr, tk}));
         @(posedge clk);
         #1 chk(32'({greet[i], resync[i]}), 32'h0);
      end
      repeat (6) @(posedge clk);
      for (int i = 0; i < NUM_LINKS; i++) begin
         tr = 11'h7F8 | 11'(i);
         tk = 11'(i * 11'h0F1);
         rd_reg(adr(CFG_BASE_IDX, i), '0, d);
         chk(d, {1'h1, i[0], 3'h0, issued[i], 1'h1, 3'h0, tr, tk});
      end
      chk(32'(held), 32'hFF);
      @(posedge clk);
      bad <= 8'h04;
      @(posedge clk);
      bad <= '0;
      #1 chk(32'(err), 32'h04);
      rd_reg(adr(CFG_BASE_IDX, 2), 8'h04, d);
      chk(32'({d[27], err[2]}), 32'h3);
      rd_reg(adr(CFG_BASE_IDX, 2), '0, d);
      chk(32'({d[27], err[2]}), 32'h2);
      rd_reg(adr(CFG_BASE_IDX, 2), '0, d);
      chk(32'(d[27]), 32'h0);
      rd_reg(12'h220, 8'h20, d);
      chk(d, UNMAPPED_DATA);
      chk(32'(err), 32'h20);
      rd_reg(adr(CFG_BASE_IDX, 5), '0, d);
      chk(32'({d[27], err[5]}), 32'h2);
      wr_reg(adr(CFG_BASE_IDX, 3), 32'h0);
      chk(32'({en[3], mux[3]}), 32'h0);
      for (int i = 0; i < NUM_LINKS; i++) begin
         c = 5'(i * 7 + 3);
         wr_reg(adr(STATIC_BASE_IDX, i), {i[0], 26'h3FFFFFF, c});
         chk(32'({sfen[i], chan[i*CHAN_W+:CHAN_W]}), 32'({i[0], c}));
         rd_reg(adr(STATIC_BASE_IDX, i), '0, d);
         chk(d, {i[0], 26'h0, c});
      end
      wr_reg(12'h000, 32'hFFFFFFFF);
      wr_reg(12'h201, 32'hFFFFFFFF);
      chk(32'(wide[0]), 32'h0);
      rd_reg(adr(CFG_BASE_IDX, 0), '0, d);
      chk(d, {1'h1, 1'h0, 3'h0, 1'h1, 1'h1, 3'h0, 11'h7F8, 11'h000});
      rd_reg(12'h201, '0, d);
      chk(d, UNMAPPED_DATA);
      report_and_stop();
   end
endmodule // lcs_link_regs_test
